// ==== pkg/sof_pkg.sv ====
package sof_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] SOF_IDX_PRESS_LOW = 8'h28;
   localparam logic [7:0] SOF_IDX_PRESS_MID = 8'h29;
   localparam logic [7:0] SOF_IDX_PRESS_HIGH = 8'h2A;
   localparam logic [7:0] SOF_IDX_TEMP_LOW = 8'h2B;
   localparam logic [7:0] SOF_IDX_TEMP_HIGH = 8'h2C;
   localparam logic [7:0] SOF_IDX_QUEUE_CTRL = 8'h2E;
   localparam logic [7:0] SOF_IDX_QUEUE_STAT = 8'h2F;
   localparam logic [7:0] SOF_IDX_ALARM_LOW = 8'h30;
   localparam logic [7:0] SOF_IDX_ALARM_HIGH = 8'h31;
   localparam logic [7:0] SOF_IDX_CAL_LOW = 8'h39;
   localparam logic [7:0] SOF_IDX_CAL_HIGH = 8'h3A;
   localparam logic [7:0] SOF_IDX_FLAGS = 8'h40;
   localparam logic [7:0] SOF_IDX_IRQ_STAT = 8'h41;
   localparam logic [7:0] SOF_IDX_IRQ_MASK = 8'h42;

   // queue control fields
   localparam int SOF_MODE_MSB = 7;
   localparam int SOF_MODE_LSB = 5;
   localparam int SOF_WTM_MSB = 4;
   localparam logic [7:0] SOF_CTRL_RST = 8'h00;

   // queue status bit positions
   localparam int SOF_STAT_WTM_BIT = 7;
   localparam int SOF_STAT_OVR_BIT = 6;
   localparam int SOF_STAT_EMPTY_BIT = 5;

   // irq status/mask bit positions
   localparam int SOF_EV_SAMPLE = 0;
   localparam int SOF_EV_WTM = 1;
   localparam int SOF_EV_OVR = 2;
   localparam int SOF_EV_ALARM = 3;

   localparam logic [5:0] SOF_DEPTH = 6'h20;
   localparam logic [1:0] SOF_RESP_OKAY = 2'h0;
   localparam logic [1:0] SOF_RESP_SLVERR = 2'h2;

   localparam logic [2:0] SOF_MODE_BYPASS = 3'h0;
   localparam logic [2:0] SOF_MODE_FILL_STOP = 3'h1;
   localparam logic [2:0] SOF_MODE_STREAM = 3'h2;
   localparam logic [2:0] SOF_MODE_STREAM_STOP = 3'h3;
   localparam logic [2:0] SOF_MODE_BYPASS_STREAM = 3'h4;
   localparam logic [2:0] SOF_MODE_AVERAGE = 3'h6;
   localparam logic [2:0] SOF_MODE_BYPASS_STOP = 3'h7;

   typedef enum logic [1:0] {
      SOF_BEH_BYPASS = 2'b00,
      SOF_BEH_HOLD = 2'b01,
      SOF_BEH_RING = 2'b10,
      SOF_BEH_MEAN = 2'b11
   } sof_beh_t;

   typedef struct packed {
      logic valid;
      logic [23:0] pressure;
      logic [15:0] temperature;
   } sof_sample_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic aw_have;
      logic [7:0] aw_idx;
      logic aw_bad;
      logic w_have;
      logic [7:0] wbyte;
      logic wen;
      logic [7:0] ctrl;
      logic [15:0] alarm;
      logic [15:0] cal;
      logic [3:0] mask;
      logic [3:0] ists;
      logic irq;
      logic pda;
      logic [23:0] last_p;
      logic [15:0] temp;
      logic [4:0] wr_ptr;
      logic [4:0] rd_ptr;
      logic [5:0] cnt;
      logic queue_overwrite_flag;
      logic trig;
      logic wtm_prev;
      logic [31:0][23:0] mem;
   } sof_state_t;

   localparam sof_state_t SOF_STATE_RST = '0;

endpackage

// ==== hdl/sof_regs.sv ====
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ns

module sof_regs (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire sof_pkg::sof_sample_t sample_in,
   input wire logic trigger_event,
   output logic irq
);
   import sof_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic known(input logic [7:0] idx);
      case (idx)
         SOF_IDX_PRESS_LOW, SOF_IDX_PRESS_MID, SOF_IDX_PRESS_HIGH,
         SOF_IDX_TEMP_LOW, SOF_IDX_TEMP_HIGH, SOF_IDX_QUEUE_CTRL,
         SOF_IDX_QUEUE_STAT, SOF_IDX_ALARM_LOW, SOF_IDX_ALARM_HIGH,
         SOF_IDX_CAL_LOW, SOF_IDX_CAL_HIGH, SOF_IDX_FLAGS,
         SOF_IDX_IRQ_STAT, SOF_IDX_IRQ_MASK: known = 1'b1;
         default: known = 1'b0;
      endcase
   endfunction

   function automatic logic [2:0] ones(input logic [4:0] v);
      ones = 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]) + 3'(v[4]);
   endfunction

   // zero and one sample both read as zero; empty flag separates them
   function automatic logic [4:0] level(input logic [5:0] cnt);
      if (cnt == 6'h00) begin
         level = 5'h00;
      end else begin
         level = 5'(cnt - 6'h01);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // state

   sof_state_t s_q;
   sof_state_t s_d;

   logic [2:0] mode;
   logic [4:0] wtm;
   sof_beh_t beh;
   logic [23:0] corr;
   logic [28:0] sum;
   logic [5:0] win;
   logic [4:0] idx;
   logic [23:0] mean;
   logic [23:0] shown;
   logic wtm_now;
   logic [7:0] rbyte;
   logic pop;
   logic [3:0] ev;
   logic [3:0] clr;

   assign s_axi_awready = s_q.awready;
   assign s_axi_wready = s_q.wready;
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_arready = s_q.arready;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rdata = s_q.rdata;
   assign s_axi_rresp = s_q.rresp;
   assign irq = s_q.irq;

   always_comb begin
      s_d = s_q;
      ev = 4'h0;
      clr = 4'h0;
      pop = 1'b0;
      rbyte = 8'h00;
      idx = 5'h00;
      mode = s_q.ctrl[SOF_MODE_MSB:SOF_MODE_LSB];
      wtm = s_q.ctrl[SOF_WTM_MSB:0];

      // triggered modes switch behaviour once the trigger was seen
      case (mode)
         SOF_MODE_BYPASS: beh = SOF_BEH_BYPASS;
         SOF_MODE_FILL_STOP: beh = SOF_BEH_HOLD;
         SOF_MODE_STREAM: beh = SOF_BEH_RING;
         SOF_MODE_STREAM_STOP: begin
            beh = s_q.trig ? SOF_BEH_HOLD : SOF_BEH_RING;
         end
         SOF_MODE_BYPASS_STREAM: begin
            beh = s_q.trig ? SOF_BEH_RING : SOF_BEH_BYPASS;
         end
         SOF_MODE_AVERAGE: beh = SOF_BEH_MEAN;
         SOF_MODE_BYPASS_STOP: begin
            beh = s_q.trig ? SOF_BEH_HOLD : SOF_BEH_BYPASS;
         end
         default: beh = SOF_BEH_BYPASS;
      endcase

      // one-point correction applied to every new sample
      corr = sample_in.pressure + {{8{s_q.cal[15]}}, s_q.cal};

      // newest win entries summed and shifted right by the ones in wtm: a moving average when win is a power of two
      win = {1'b0, wtm} + 6'h01;
      sum = 29'h0;
      for (int k = 0; k < 32; k++) begin
         idx = s_q.wr_ptr - 5'(k) - 5'h01;
         if (6'(k) < win) begin
            sum = sum + {{5{s_q.mem[idx][23]}}, s_q.mem[idx]};
         end
      end
      mean = 24'($signed(sum) >>> ones(wtm));

      if (beh == SOF_BEH_MEAN) begin
         shown = mean;
      end else if (beh == SOF_BEH_BYPASS || s_q.cnt == 6'h00) begin
         shown = s_q.last_p;
      end else begin
         shown = s_q.mem[s_q.rd_ptr];
      end

      wtm_now = s_q.cnt >= {1'b0, wtm};

      ////////////////////////////////////////////////////////////////////
      // write channel

      if (s_axi_awvalid && s_q.awready) begin
         s_d.aw_have = 1'b1;
         s_d.aw_idx = s_axi_awaddr[9:2];
         s_d.aw_bad = |s_axi_awaddr[11:10];
      end
      if (s_axi_wvalid && s_q.wready) begin
         s_d.w_have = 1'b1;
         s_d.wbyte = s_axi_wdata[7:0];
         s_d.wen = s_axi_wstrb[0];
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
         s_d.aw_have = 1'b0;
         s_d.w_have = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = SOF_RESP_OKAY;
         if (s_q.aw_bad || !known(s_q.aw_idx)) begin
            s_d.bresp = SOF_RESP_SLVERR;
         end else if (s_q.wen) begin
            case (s_q.aw_idx)
               SOF_IDX_QUEUE_CTRL: begin
                  s_d.ctrl = s_q.wbyte;
                  if (s_q.wbyte[SOF_MODE_MSB:SOF_MODE_LSB] != mode) begin
                     s_d.trig = 1'b0;
                     s_d.cnt = 6'h00;
                     s_d.wr_ptr = 5'h00;
                     s_d.rd_ptr = 5'h00;
                     s_d.queue_overwrite_flag = 1'b0;
                     s_d.mem = '0;
                  end
               end
               SOF_IDX_ALARM_LOW: s_d.alarm[7:0] = s_q.wbyte;
               SOF_IDX_ALARM_HIGH: s_d.alarm[15:8] = s_q.wbyte;
               SOF_IDX_CAL_LOW: s_d.cal[7:0] = s_q.wbyte;
               SOF_IDX_CAL_HIGH: s_d.cal[15:8] = s_q.wbyte;
               SOF_IDX_IRQ_STAT: clr = s_q.wbyte[3:0];
               SOF_IDX_IRQ_MASK: s_d.mask = s_q.wbyte[3:0];
               default: ;
            endcase
         end
      end
      s_d.awready = !s_d.aw_have && !s_d.bvalid;
      s_d.wready = !s_d.w_have && !s_d.bvalid;

      ////////////////////////////////////////////////////////////////////
      // read channel

      if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_q.arready) begin
         s_d.rvalid = 1'b1;
         s_d.rresp = SOF_RESP_OKAY;
         if (|s_axi_araddr[11:10] || !known(s_axi_araddr[9:2])) begin
            s_d.rresp = SOF_RESP_SLVERR;
         end else begin
            case (s_axi_araddr[9:2])
               SOF_IDX_PRESS_LOW: rbyte = shown[7:0];
               SOF_IDX_PRESS_MID: rbyte = shown[15:8];
               SOF_IDX_PRESS_HIGH: begin
                  rbyte = shown[23:16];
                  s_d.pda = 1'b0;
                  pop = (beh == SOF_BEH_HOLD || beh == SOF_BEH_RING)
                     && s_q.cnt != 6'h00;
               end
               SOF_IDX_TEMP_LOW: rbyte = s_q.temp[7:0];
               SOF_IDX_TEMP_HIGH: rbyte = s_q.temp[15:8];
               SOF_IDX_QUEUE_CTRL: rbyte = s_q.ctrl;
               SOF_IDX_QUEUE_STAT: begin
                  rbyte[SOF_STAT_WTM_BIT] = wtm_now;
                  rbyte[SOF_STAT_OVR_BIT] = s_q.queue_overwrite_flag;
                  rbyte[SOF_STAT_EMPTY_BIT] = s_q.cnt == 6'h00;
                  rbyte[4:0] = level(s_q.cnt);
               end
               SOF_IDX_ALARM_LOW: rbyte = s_q.alarm[7:0];
               SOF_IDX_ALARM_HIGH: rbyte = s_q.alarm[15:8];
               SOF_IDX_CAL_LOW: rbyte = s_q.cal[7:0];
               SOF_IDX_CAL_HIGH: rbyte = s_q.cal[15:8];
               SOF_IDX_FLAGS: rbyte = {7'h00, s_q.pda};
               SOF_IDX_IRQ_STAT: rbyte = {4'h0, s_q.ists};
               SOF_IDX_IRQ_MASK: rbyte = {4'h0, s_q.mask};
               default: rbyte = 8'h00;
            endcase
         end
         s_d.rdata = {24'h000000, rbyte};
      end
      s_d.arready = !s_d.rvalid;

      ////////////////////////////////////////////////////////////////////
      // queue: pop first, then push, so both may meet in one cycle

      if (pop) begin
         s_d.rd_ptr = s_q.rd_ptr + 5'h01;
         s_d.cnt = s_q.cnt - 6'h01;
         s_d.queue_overwrite_flag = 1'b0;
      end
      if (sample_in.valid) begin
         s_d.last_p = corr;
         s_d.temp = sample_in.temperature;
         s_d.pda = 1'b1;
         ev[SOF_EV_SAMPLE] = 1'b1;
         // alarm level is in 1/16 hPa, pressure in 1/4096 hPa
         if ($signed({corr[23], corr}) > $signed({1'b0, s_q.alarm, 8'h00}))
         begin
            ev[SOF_EV_ALARM] = 1'b1;
         end
         case (beh)
            SOF_BEH_BYPASS: begin
               s_d.cnt = 6'h00;
               s_d.wr_ptr = 5'h00;
               s_d.rd_ptr = 5'h00;
               s_d.queue_overwrite_flag = 1'b0;
            end
            SOF_BEH_HOLD: begin
               if (s_d.cnt != SOF_DEPTH) begin
                  s_d.mem[s_d.wr_ptr] = corr;
                  s_d.wr_ptr = s_d.wr_ptr + 5'h01;
                  s_d.cnt = s_d.cnt + 6'h01;
               end
            end
            SOF_BEH_RING, SOF_BEH_MEAN: begin
               if (s_d.cnt == SOF_DEPTH) begin
                  s_d.rd_ptr = s_d.rd_ptr + 5'h01;
                  if (beh == SOF_BEH_RING) begin
                     s_d.queue_overwrite_flag = 1'b1;
                     ev[SOF_EV_OVR] = 1'b1;
                  end
               end else begin
                  s_d.cnt = s_d.cnt + 6'h01;
               end
               s_d.mem[s_d.wr_ptr] = corr;
               s_d.wr_ptr = s_d.wr_ptr + 5'h01;
            end
            default: ;
         endcase
      end
      if (trigger_event) begin
         s_d.trig = 1'b1;
      end

      ////////////////////////////////////////////////////////////////////
      // interrupts: a new event wins over a clear in the same cycle

      ev[SOF_EV_WTM] = wtm_now && !s_q.wtm_prev;
      s_d.wtm_prev = wtm_now;
      s_d.ists = (s_q.ists & ~clr) | ev;
      s_d.irq = |(s_d.ists & s_d.mask);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= SOF_STATE_RST;
      end else begin
         s_q <= s_d;
      end
   end

endmodule

// ==== sim/sof_regs_checker.sv ====
`timescale 1ns/1ns
module sof_regs_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire sof_pkg::sof_sample_t sample_in,
   input wire logic irq
);
   import sof_pkg::*;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [7:0] ar_idx_q;
   logic [15:0] temp_q;
   ////////////////////////////////////////
   // remembers the read index and the newest temperature
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ar_idx_q <= '0;
         temp_q <= '0;
      end else begin
         if (s_axi_arvalid && s_axi_arready)
            ar_idx_q <= s_axi_araddr[9:2];
         if (sample_in.valid)
            temp_q <= sample_in.temperature;
      end
   end
   ////////////////////////////////////////
   AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write not answered two cycles after capture");
   AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("read not answered next cycle");
   AST_READ_HOLD: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before taken");
   AST_RESP_HOLD: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");
   AST_READ_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address accepted during read answer");
   AST_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready &&
      s_axi_araddr[9:2] > SOF_IDX_IRQ_MASK
      |=> s_axi_rresp == SOF_RESP_SLVERR && s_axi_rdata == '0)
      else $error("unmapped read not refused");
   AST_UPPER_ZERO: assert property (s_axi_rvalid |->
      s_axi_rdata[31:8] == '0) else $error("read data above byte set");
   AST_TEMP_LOW: assert property ($rose(s_axi_rvalid) &&
      ar_idx_q == SOF_IDX_TEMP_LOW |-> s_axi_rdata[7:0] == temp_q[7:0])
      else $error("temperature low byte wrong");
   AST_TEMP_HIGH: assert property ($rose(s_axi_rvalid) &&
      ar_idx_q == SOF_IDX_TEMP_HIGH |-> s_axi_rdata[7:0] == temp_q[15:8])
      else $error("temperature high byte wrong");
   cover property (s_axi_rvalid && s_axi_rresp == SOF_RESP_SLVERR);
   cover property ($rose(irq));
   cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind sof_regs sof_regs_checker i_chk (
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample_in, .irq
);

// ==== sim/sof_host.sv ====
`timescale 1ns/1ns
module sof_host (
   input wire logic aclk,
   output logic [11:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [11:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   // when set, bready and rready are raised only once the answer is seen
   logic lazy = 1'b0;
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid,
       s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
   end
   ////////////////////////////////////////
   // released payload is inverted so stale values never look valid
   task automatic write_reg(input logic [7:0] idx, input logic [7:0] val,
                            output logic [1:0] resp);
      @(posedge aclk);
      s_axi_awaddr <= {2'h0, idx, 2'h0};
      s_axi_wdata <= {24'h0, val};
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= !lazy;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~s_axi_wdata;
         end
         if (s_axi_bvalid && !s_axi_bready) begin
            s_axi_bready <= 1'b1;
         end
      end while (!(s_axi_bvalid && s_axi_bready));
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic read_reg(input logic [7:0] idx, output logic [31:0] data,
                           output logic [1:0] resp);
      @(posedge aclk);
      s_axi_araddr <= {2'h0, idx, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= !lazy;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
            s_axi_araddr <= ~s_axi_araddr;
         end
         if (s_axi_rvalid && !s_axi_rready) begin
            s_axi_rready <= 1'b1;
         end
      end while (!(s_axi_rvalid && s_axi_rready));
      data = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
endmodule

// ==== sim/sof_regs_bench.sv ====
`timescale 1ns/1ns
module sof_regs_bench;
   import sof_pkg::*;
   logic aclk, aresetn, trigger_event, irq;
   sof_sample_t sample_in;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [7:0] rv;
   logic [15:0] t, cal;
   logic [23:0] p, e24;
   logic [23:0] pq [33];
   int errors, num_checks, seed, i, k, acc;
   localparam logic [7:0] RWR [4] = '{SOF_IDX_ALARM_LOW, SOF_IDX_ALARM_HIGH,
                                     SOF_IDX_CAL_LOW, SOF_IDX_CAL_HIGH};
   sof_regs i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample_in,
      .trigger_event, .irq);
   sof_host i_host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   ////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e, g);
      num_checks++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", nm, e, g);
         errors++;
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      i_host.write_reg(idx, v, rs);
      chk("bresp", {30'h0, SOF_RESP_OKAY}, {30'h0, rs});
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] e);
      i_host.read_reg(idx, d, rs);
      chk($sformatf("reg %h", idx), {24'h0, e}, d);
      chk("rresp", {30'h0, SOF_RESP_OKAY}, {30'h0, rs});
   endtask
   task automatic samp(input logic [23:0] pr);
      t = 16'($random(seed));
      @(posedge aclk);
      sample_in <= '{1'b1, pr, t};
      @(posedge aclk);
      sample_in.valid <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic ci(input logic e);
      #1;
      chk("irq", {31'h0, e}, {31'h0, irq});
   endtask
   function automatic logic [7:0] stat(int n, int w, logic o);
      return {n >= w, o, n == 0, n == 0 ? 5'h0 : 5'(n - 1)};
   endfunction
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge aclk);
      errors++;
      print_verdict();
   end
   initial begin
      seed = 32'hFB15;
      aresetn = 1'b0;
      sample_in = '0;
      trigger_event = 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(SOF_IDX_QUEUE_CTRL, SOF_CTRL_RST);
      rd(SOF_IDX_QUEUE_STAT, stat(0, 0, 1'b0));
      $display("test reset done");
      i_host.lazy = 1'b1;
      for (i = 0; i < 4; i++) begin
         rv = 8'($random(seed));
         wr(RWR[i], rv);
         rd(RWR[i], rv);
      end
      i_host.lazy = 1'b0;
      wr(SOF_IDX_TEMP_HIGH, 8'h5A);
      rd(SOF_IDX_TEMP_HIGH, 8'h00);
      i_host.read_reg(8'h50, d, rs);
      chk("unmapped rresp", {30'h0, SOF_RESP_SLVERR}, {30'h0, rs});
      i_host.write_reg(8'h50, 8'h11, rs);
      chk("unmapped bresp", {30'h0, SOF_RESP_SLVERR}, {30'h0, rs});
      for (i = 0; i < 8; i++) if (i != 5) begin
         trigger_event <= 1'($random(seed));
         wr(SOF_IDX_QUEUE_CTRL, {3'(i), 5'h0A});
         rd(SOF_IDX_QUEUE_CTRL, {3'(i), 5'h0A});
      end
      $display("test registers done");
      wr(SOF_IDX_QUEUE_CTRL, {SOF_MODE_BYPASS, 5'h00});
      for (k = 0; k < 4; k++) begin
         cal = 16'($random(seed));
         wr(SOF_IDX_CAL_LOW, cal[7:0]);
         wr(SOF_IDX_CAL_HIGH, cal[15:8]);
         p = 24'($random(seed));
         samp(p);
         e24 = p + {{8{cal[15]}}, cal};
         rd(SOF_IDX_PRESS_LOW, e24[7:0]);
         rd(SOF_IDX_PRESS_MID, e24[15:8]);
         rd(SOF_IDX_FLAGS, 8'h01);
         rd(SOF_IDX_PRESS_HIGH, e24[23:16]);
         rd(SOF_IDX_FLAGS, 8'h00);
         rd(SOF_IDX_TEMP_LOW, t[7:0]);
         rd(SOF_IDX_TEMP_HIGH, t[15:8]);
      end
      wr(SOF_IDX_CAL_LOW, 8'h00);
      wr(SOF_IDX_CAL_HIGH, 8'h00);
      $display("test results done");
      wr(SOF_IDX_QUEUE_CTRL, {SOF_MODE_STREAM, 5'd3});
      rd(SOF_IDX_QUEUE_STAT, stat(0, 3, 1'b0));
      for (i = 0; i < 33; i++) begin
         pq[i] = 24'($random(seed));
         samp(pq[i]);
         rd(SOF_IDX_QUEUE_STAT, stat(i < 32 ? i + 1 : 32, 3, i == 32));
      end
      rd(SOF_IDX_PRESS_LOW, pq[1][7:0]);
      rd(SOF_IDX_PRESS_HIGH, pq[1][23:16]);
      rd(SOF_IDX_QUEUE_STAT, stat(31, 3, 1'b0));
      wr(SOF_IDX_QUEUE_CTRL, {SOF_MODE_FILL_STOP, 5'd31});
      for (i = 0; i < 33; i++) samp(pq[i]);
      rd(SOF_IDX_QUEUE_STAT, stat(32, 31, 1'b0));
      rd(SOF_IDX_PRESS_HIGH, pq[0][23:16]);
      $display("test queue done");
      for (k = 1; k < 6; k++) begin
         wr(SOF_IDX_QUEUE_CTRL, {SOF_MODE_AVERAGE, 5'((1 << k) - 1)});
         acc = 0;
         for (i = 0; i < (1 << k); i++) begin
            p = 24'($random(seed)) & 24'h3FFFFF;
            acc += int'(p);
            samp(p);
         end
         acc = acc >>> k;
         rd(SOF_IDX_PRESS_LOW, acc[7:0]);
         rd(SOF_IDX_PRESS_HIGH, acc[23:16]);
      end
      $display("test average done");
      trigger_event <= 1'b0;
      wr(SOF_IDX_QUEUE_CTRL, {SOF_MODE_BYPASS_STOP, 5'h01});
      samp(24'h123456);
      rd(SOF_IDX_QUEUE_STAT, stat(0, 1, 1'b0));
      trigger_event <= 1'b1;
      samp(24'h0ABCDE);
      trigger_event <= 1'b0;
      rd(SOF_IDX_QUEUE_STAT, stat(1, 1, 1'b0));
      rd(SOF_IDX_PRESS_HIGH, 8'h0A);
      $display("test trigger done");
      wr(SOF_IDX_QUEUE_CTRL, {SOF_MODE_BYPASS, 5'h00});
      wr(SOF_IDX_IRQ_STAT, 8'h0F);
      wr(SOF_IDX_IRQ_MASK, 8'h01);
      ci(1'b0);
      samp(24'($random(seed)));
      ci(1'b1);
      wr(SOF_IDX_IRQ_MASK, 8'h00);
      ci(1'b0);
      wr(SOF_IDX_IRQ_MASK, 8'h01);
      ci(1'b1);
      wr(SOF_IDX_IRQ_STAT, 8'h01);
      ci(1'b0);
      $display("test interrupt done");
      print_verdict();
   end
endmodule
